// *** core/rx_debug_serial_streamer.sv ***
/*
 Receive-path debug streamer: Wishbone control/status, 1 us snapshot of the
 selected probe vector, 16-word FIFO, and a three-pin serial output.
 Assumes probe signals are synchronous to mclk; the serial clock arrives as
 an asynchronous free-running input and is sampled by mclk.
*/
// Our own choices: the Wishbone register port and the register addresses.
// Notes on behaviour
// - Non-zero select with both test modes off switches the three pins to debug.
// - In debug mode the three pins carry the serial stream instead of normal use.
// - Clock pin carries the running serial clock throughout debug mode.
// - Data changes on serial clock rise, stable for capture at the fall.
// - Words are sixteen bits, most significant bit first.
// - Sync pin high only during the bit 0 slot of each word.
// - Next word's top bit follows the sync slot with no gap.
// - Selected vector captured in parallel once per microsecond, one word each.
// - Select 1: Status_a, IF settled, RSSI settled, raw RSSI ADC.
// - Select 2: filtered RSSI, low-gain flag, above, below, outside flags.
// - Select 3: first filter stage, I and Q limiter, XOR demod, IF settled.
// - Select 4: interpolated baseband and its valid flag.
// - Select 5: initial slicer threshold and unstretched reload pulse.
// - Select 6: current slicer threshold and its reload pulse.
// - Select 7: offset-binary phase error on top byte, low byte zero.
// - Select 8 top six: frame, data, bit clock, match, chip clock, edge.
// - Select 8 low ten: deglitcher, slicer, baseband, ready and settled flags.
// - Select 9: timeout, monitor, chip check, baud, RSSI and amplitude flags.
`default_nettype none

module debug_word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16,
   localparam int AW = $clog2(DEPTH),
   localparam int CW = $clog2(DEPTH + 1)
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [CW-1:0] level
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [CW-1:0] count;
   } fifo_state_t;

   fifo_state_t st_q;
   fifo_state_t st_d;
   logic push;
   logic pop;

   assign in_ready = st_q.count != CW'(DEPTH);
   assign out_valid = st_q.count != '0;
   assign out_data = st_q.mem[st_q.rd];
   assign level = st_q.count;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      st_d = st_q;
      if (push) begin
         st_d.mem[st_q.wr] = in_data;
         st_d.wr = (st_q.wr == AW'(DEPTH - 1)) ? '0 : st_q.wr + AW'(1);
      end
      if (pop) begin
         st_d.rd = (st_q.rd == AW'(DEPTH - 1)) ? '0 : st_q.rd + AW'(1);
      end
      st_d.count = st_q.count + CW'(push) - CW'(pop);
      // Flush discards queued words; the streamer drives it only while debug mode is off, so a direct change of select keeps them
      if (flush) begin
         st_d.wr = '0;
         st_d.rd = '0;
         st_d.count = '0;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   a_fifo_no_overfill: assert property (@(posedge mclk) disable iff (reset)
      st_q.count <= CW'(DEPTH))
      else $error("fifo count above depth");

endmodule : debug_word_fifo

module rx_debug_serial_streamer
   import rx_debug_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [rx_debug_pkg::ADR_BITS-1:0] wb_adr,
   input wire logic [3:0] wb_sel,
   input wire logic [31:0] wb_dat_w,
   output logic [31:0] wb_dat_r,
   output logic wb_ack,
   input wire rx_debug_pkg::rx_probe_t probe,
   input wire logic link_clock,
   input wire rx_debug_pkg::pin_drive_t normal_pins,
   output rx_debug_pkg::pin_drive_t pins
);
   import rx_debug_pkg::*;

   localparam int CW = $clog2(FIFO_DEPTH + 1);
   localparam int RUN_BITS = TICK_BITS + 1;

   typedef struct packed {
      logic [SEL_BITS-1:0] debug_vector_select;
      logic scan_test_enable;
      logic filter_multitone_test_enable;
      logic lclk_s1;
      logic lclk_s2;
      logic lclk_s3;
      logic [TICK_BITS-1:0] tick;
      logic [WORD_BITS-1:0] shift;
      logic [WORD_BITS-1:0] hold;
      logic [3:0] slot;
      logic data;
      logic sync;
      logic ack;
      logic [31:0] rdata;
      logic [15:0] words_sent;
      logic [15:0] dropped;
      logic [RUN_BITS-1:0] active_run;
   } streamer_state_t;

   streamer_state_t st_q;
   streamer_state_t st_d;

   logic active;
   logic rise;
   logic sample_tick;
   logic [WORD_BITS-1:0] vec;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_pop;
   logic [WORD_BITS-1:0] fifo_out_data;
   logic [CW-1:0] fifo_level;
   logic bus_req;

   function automatic logic [WORD_BITS-1:0] pick_vector(input logic [3:0] s, input rx_probe_t p);
      logic [WORD_BITS-1:0] v;
      v = 16'h0000;
      case (s)
         SEL_RSSI: v = {p.status_a, p.if_settled, p.rssi_settled, p.rssi_adc_raw};
         SEL_RSSI_FILT: v = {p.rssi_filtered, p.front_end_low_gain, p.rssi_above_upper,
                             p.rssi_below_lower, p.rssi_outside};
         SEL_BB_STAGE1: v = {p.bb_stage1, p.lim_i, p.lim_q, p.xor_demod, p.if_settled};
         SEL_BASEBAND: v = {p.baseband, p.baseband_valid};
         // Reload pulses are sampled as they are; short ones can fall between captures
         SEL_SLICER_INIT: v = {p.slicer_init_thr, p.load_init_thr};
         SEL_SLICER_THR: v = {p.slicer_thr, p.load_thr};
         SEL_PHASE_ERR: v = {p.phase_error, 8'h00};
         SEL_DATA_FLAGS: v = {p.rx_frame, p.rx_data, p.rx_bit_clock, p.pattern_match,
                              p.chip_clock, p.edge_detected,
                              p.deglitched_level, p.deglitched_valid, p.slicer_result,
                              p.slicer_ready, p.slicer_valid, p.baseband_valid, p.rx_ready,
                              p.if_settled_slow, p.if_settled, p.analog_ready};
         SEL_CHECK_FLAGS: v = {p.cmd_timeout, p.monitor_fail, p.monitor_pass, p.timeout_active,
                               p.chip_timeout, p.single_chip_error, p.code_error,
                               p.chip_check_valid, p.baud_error, p.baud_valid, p.rssi_outside,
                               p.rssi_settled, p.amp_too_high, p.amp_too_high_valid,
                               p.amp_too_low, p.amp_too_low_valid};
         default: v = 16'h0000;
      endcase
      return v;
   endfunction : pick_vector

   // Debug ownership of the pins; any test mode takes them back
   assign active = (st_q.debug_vector_select != SEL_OFF) && !st_q.scan_test_enable
                   && !st_q.filter_multitone_test_enable;
   assign rise = st_q.lclk_s2 && !st_q.lclk_s3;
   assign sample_tick = active && (st_q.tick == TICK_BITS'(SAMPLE_CYCLES - 1));
   assign vec = pick_vector(st_q.debug_vector_select, probe);
   assign fifo_pop = active && rise && (st_q.slot == SYNC_SLOT);
   assign bus_req = wb_cyc && wb_stb;

   debug_word_fifo #(
      .WIDTH(WORD_BITS),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .reset(reset),
      .flush(!active),
      .in_valid(sample_tick),
      .in_ready(fifo_in_ready),
      .in_data(vec),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out_data),
      .level(fifo_level)
   );

   always_comb begin
      logic [WORD_BITS-1:0] next_word;
      next_word = fifo_out_valid ? fifo_out_data : st_q.hold;
      st_d = st_q;

      // Serial clock is asynchronous: two flops before anything looks at it
      st_d.lclk_s1 = link_clock;
      st_d.lclk_s2 = st_q.lclk_s1;
      st_d.lclk_s3 = st_q.lclk_s2;

      // Microsecond capture timer
      if (!active || sample_tick) begin
         st_d.tick = '0;
      end else begin
         st_d.tick = st_q.tick + TICK_BITS'(1);
      end
      // Saturating run length of debug mode, kept only for the capture-period check
      if (!active) begin
         st_d.active_run = '0;
      end else if (st_q.active_run != '1) begin
         st_d.active_run = st_q.active_run + RUN_BITS'(1);
      end
      if (sample_tick && !fifo_in_ready) begin
         // Capture lost while the link is slower than the sample rate
         st_d.dropped = st_q.dropped + 16'h0001;
      end

      // Serializer advances only on a detected serial clock rise
      if (!active) begin
         st_d.slot = SYNC_SLOT;
         st_d.data = 1'b0;
         st_d.sync = 1'b0;
      end else if (rise) begin
         if (st_q.slot == SYNC_SLOT) begin
            // An empty FIFO repeats the last word so the stream never gaps
            st_d.shift = next_word;
            st_d.hold = next_word;
            st_d.slot = MSB_SLOT;
            st_d.data = next_word[WORD_BITS-1];
            st_d.sync = 1'b0;
            st_d.words_sent = st_q.words_sent + 16'h0001;
         end else begin
            st_d.slot = st_q.slot - 4'h1;
            st_d.data = st_q.shift[st_q.slot - 4'h1];
            st_d.sync = (st_q.slot - 4'h1) == SYNC_SLOT;
         end
      end

      // Classic Wishbone slave: one wait state, write lands on the ack edge
      st_d.ack = bus_req && !st_q.ack;
      if (bus_req && !st_q.ack) begin
         case (wb_adr)
            CTRL_OFS: st_d.rdata = {26'h0000000, st_q.filter_multitone_test_enable,
                                    st_q.scan_test_enable, st_q.debug_vector_select};
            STATUS_OFS: st_d.rdata = {st_q.words_sent, 7'h00, fifo_level, 3'h0, active};
            DROP_OFS: st_d.rdata = {16'h0000, st_q.dropped};
            default: st_d.rdata = 32'h00000000;
         endcase
      end
      if (bus_req && st_q.ack && wb_we && wb_sel[0] && wb_adr == CTRL_OFS) begin
         st_d.debug_vector_select = wb_dat_w[SEL_LSB +: SEL_BITS];
         st_d.scan_test_enable = wb_dat_w[SCAN_BIT];
         st_d.filter_multitone_test_enable = wb_dat_w[MTONE_BIT];
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign wb_ack = st_q.ack;
   assign wb_dat_r = st_q.rdata;

   // Pin ownership; clock pin follows the resynchronised serial clock
   always_comb begin
      if (active) begin
         pins.data_out = st_q.data;
         pins.sync_out = st_q.sync;
         pins.clk_out = st_q.lclk_s2;
         pins.data_oe_n = 1'b0;
         pins.sync_oe_n = 1'b0;
         pins.clk_oe_n = 1'b0;
      end else begin
         pins = normal_pins;
      end
   end

   a_pins_owned: assert property (@(posedge mclk) disable iff (reset)
      active |-> !pins.data_oe_n && !pins.sync_oe_n && !pins.clk_oe_n)
      else $error("debug pins not driven in debug mode");

   a_pins_released: assert property (@(posedge mclk) disable iff (reset)
      (st_q.debug_vector_select == SEL_OFF || st_q.scan_test_enable) |-> pins == normal_pins)
      else $error("pins not returned to normal use");

   a_mode_entry: assert property (@(posedge mclk) disable iff (reset)
      (st_q.debug_vector_select != SEL_OFF && !st_q.scan_test_enable
       && !st_q.filter_multitone_test_enable) |-> pins.clk_oe_n == 1'b0)
      else $error("nonzero select did not enter debug mode");

   a_clock_follows: assert property (@(posedge mclk) disable iff (reset)
      active |-> pins.clk_out == $past(link_clock, 2))
      else $error("clock pin does not follow serial clock");

   a_data_on_rise: assert property (@(posedge mclk) disable iff (reset)
      active && $past(active) && !$past(rise) |-> $stable(st_q.data) && $stable(st_q.sync))
      else $error("data changed away from a clock rise");

   a_sync_slot: assert property (@(posedge mclk) disable iff (reset)
      st_q.sync |-> st_q.slot == SYNC_SLOT)
      else $error("sync outside bit 0 slot");

   a_word_wrap: assert property (@(posedge mclk) disable iff (reset)
      active && rise && st_q.sync |=> !st_q.sync && st_q.slot == MSB_SLOT
      && st_q.data == st_q.shift[WORD_BITS-1])
      else $error("next word does not start at its top bit");

   a_sample_rate: assert property (@(posedge mclk) disable iff (reset)
      sample_tick |-> ##20 (sample_tick || !active
      || st_q.active_run < RUN_BITS'(SAMPLE_CYCLES)))
      else $error("capture period is not one microsecond");

   a_phase_low_zero: assert property (@(posedge mclk) disable iff (reset)
      st_q.debug_vector_select == SEL_PHASE_ERR |-> vec[7:0] == 8'h00
      && vec[15:8] == probe.phase_error)
      else $error("phase error vector layout wrong");

   a_rssi_layout: assert property (@(posedge mclk) disable iff (reset)
      st_q.debug_vector_select == SEL_RSSI |-> vec[15:8] == probe.status_a
      && vec[5:0] == probe.rssi_adc_raw)
      else $error("rssi vector layout wrong");

endmodule : rx_debug_serial_streamer

`default_nettype wire

// *** core/rx_debug_pkg.sv ***
/*
 Shared constants and carrier types for the receive-path debug streamer:
 register map, field positions, select codes, timing counts, probe bundle.
 Assumes a 20 MHz system clock and a 32-bit classic Wishbone register bus.
*/
`default_nettype none

package rx_debug_pkg;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] DROP_OFS = 8'h08;
   localparam int ADR_BITS = 8;

   // Control register fields
   localparam int SEL_LSB = 0;
   localparam int SEL_BITS = 4;
   localparam int SCAN_BIT = 4;
   localparam int MTONE_BIT = 5;
   localparam logic [3:0] SEL_RESET = 4'h0;

   // Status register fields
   localparam int ST_ACTIVE_BIT = 0;
   localparam int ST_LEVEL_LSB = 4;
   localparam int ST_SENT_LSB = 16;

   // Serial word
   localparam int WORD_BITS = 16;
   localparam logic [3:0] MSB_SLOT = 4'hF;
   localparam logic [3:0] SYNC_SLOT = 4'h0;
   localparam int FIFO_DEPTH = 16;

   // Snapshot rate: one parallel capture per microsecond
   localparam int MCLK_PERIOD_NS = 50;
   localparam int SAMPLE_PERIOD_NS = 1000;
   localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / MCLK_PERIOD_NS;
   localparam int TICK_BITS = 5;

   // Vector select codes
   localparam logic [3:0] SEL_OFF = 4'h0;
   localparam logic [3:0] SEL_RSSI = 4'h1;
   localparam logic [3:0] SEL_RSSI_FILT = 4'h2;
   localparam logic [3:0] SEL_BB_STAGE1 = 4'h3;
   localparam logic [3:0] SEL_BASEBAND = 4'h4;
   localparam logic [3:0] SEL_SLICER_INIT = 4'h5;
   localparam logic [3:0] SEL_SLICER_THR = 4'h6;
   localparam logic [3:0] SEL_PHASE_ERR = 4'h7;
   localparam logic [3:0] SEL_DATA_FLAGS = 4'h8;
   localparam logic [3:0] SEL_CHECK_FLAGS = 4'h9;

   typedef struct packed {
      logic [7:0] status_a;
      logic if_settled;
      logic rssi_settled;
      logic [5:0] rssi_adc_raw;
      logic [11:0] rssi_filtered;
      logic front_end_low_gain;
      logic rssi_above_upper;
      logic rssi_below_lower;
      logic rssi_outside;
      logic [11:0] bb_stage1;
      logic lim_i;
      logic lim_q;
      logic xor_demod;
      logic [14:0] baseband;
      logic baseband_valid;
      logic [14:0] slicer_init_thr;
      logic load_init_thr;
      logic [14:0] slicer_thr;
      logic load_thr;
      logic [7:0] phase_error;
      logic rx_frame;
      logic rx_data;
      logic rx_bit_clock;
      logic pattern_match;
      logic chip_clock;
      logic edge_detected;
      logic deglitched_level;
      logic deglitched_valid;
      logic slicer_result;
      logic slicer_ready;
      logic slicer_valid;
      logic rx_ready;
      logic if_settled_slow;
      logic analog_ready;
      logic cmd_timeout;
      logic monitor_fail;
      logic monitor_pass;
      logic timeout_active;
      logic chip_timeout;
      logic single_chip_error;
      logic code_error;
      logic chip_check_valid;
      logic baud_error;
      logic baud_valid;
      logic amp_too_high;
      logic amp_too_high_valid;
      logic amp_too_low;
      logic amp_too_low_valid;
   } rx_probe_t;

   // One two-way pin group: value and active-low output enable per pin
   typedef struct packed {
      logic data_out;
      logic data_oe_n;
      logic sync_out;
      logic sync_oe_n;
      logic clk_out;
      logic clk_oe_n;
   } pin_drive_t;

endpackage : rx_debug_pkg

`default_nettype wire

// *** test/debug_capture_model.sv ***
/*
 Capture side of the three-pin debug stream: makes the free-running link
 clock and decodes words from the pins.
 Assumes the bench raises enable only while the pins are in debug mode.
*/
`default_nettype none

module debug_capture_model #(
   parameter int HALF_NS = 200
) (
   input wire logic enable,
   input wire rx_debug_pkg::pin_drive_t pins,
   output logic link_clock,
   output logic [15:0] last_word,
   output int word_count,
   output int frame_errors
);
   timeunit 1ns;
   timeprecision 1ns;
   import rx_debug_pkg::*;

   logic [15:0] shift_q;
   int bits;
   logic fresh;

   // The debug clock runs continuously, so it is not stopped between words
   initial begin
      link_clock = 1'b0;
      last_word = 16'h0;
      word_count = 0;
      frame_errors = 0;
      shift_q = 16'h0;
      bits = 0;
      fresh = 1'b1;
      forever #(HALF_NS) link_clock = ~link_clock;
   end

   // First word after entry may be partial, so its length is not judged
   always @(posedge enable) begin
      fresh = 1'b1;
      bits = 0;
   end

   // Data is taken at the falling edge, half a bit after it changed
   always @(negedge pins.clk_out) begin
      if (enable && pins.clk_oe_n === 1'b0) begin
         shift_q = {shift_q[14:0], pins.data_out};
         bits++;
         if (pins.sync_out === 1'b1) begin
            if (!fresh && bits != 16) frame_errors++;
            last_word = shift_q;
            word_count++;
            bits = 0;
            fresh = 1'b0;
         end
      end
   end

endmodule : debug_capture_model

`default_nettype wire

// *** test/tb_top.sv ***
/*
 Self-checking bench for the receive-path debug streamer.
 Assumes a 20 MHz mclk, Wishbone register access and the capture model.
*/
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import rx_debug_pkg::*;

   logic mclk, reset, wb_cyc, wb_stb, wb_we, wb_ack, link_clock, cap_en;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_dat_w, wb_dat_r, rd;
   logic [159:0] rnd;
   logic [15:0] last_word;
   rx_probe_t probe;
   pin_drive_t normal_pins, pins;
   int word_count, frame_errors, fail_count, num_checks;

   rx_debug_serial_streamer dut_u (.mclk(mclk), .reset(reset), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
      .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
      .wb_ack(wb_ack), .probe(probe), .link_clock(link_clock), .normal_pins(normal_pins), .pins(pins));

   debug_capture_model cap_u (.enable(cap_en), .pins(pins), .link_clock(link_clock),
      .last_word(last_word), .word_count(word_count), .frame_errors(frame_errors));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] dw);
      int n;
      @(posedge mclk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_sel <= sel;
      wb_dat_w <= dw;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      chk("wb_ack", 32'(wb_ack), 32'h1);
      rd = wb_dat_r;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask : wb

   function automatic logic [15:0] expect_word(input logic [3:0] s, input rx_probe_t p);
      case (s)
         4'h1: return {p.status_a, p.if_settled, p.rssi_settled, p.rssi_adc_raw};
         4'h2: return {p.rssi_filtered, p.front_end_low_gain, p.rssi_above_upper, p.rssi_below_lower,
            p.rssi_outside};
         4'h3: return {p.bb_stage1, p.lim_i, p.lim_q, p.xor_demod, p.if_settled};
         4'h4: return {p.baseband, p.baseband_valid};
         4'h5: return {p.slicer_init_thr, p.load_init_thr};
         4'h6: return {p.slicer_thr, p.load_thr};
         4'h7: return {p.phase_error, 8'h00};
         4'h8: return {p.rx_frame, p.rx_data, p.rx_bit_clock, p.pattern_match, p.chip_clock,
            p.edge_detected, p.deglitched_level, p.deglitched_valid, p.slicer_result, p.slicer_ready,
            p.slicer_valid, p.baseband_valid, p.rx_ready, p.if_settled_slow, p.if_settled,
            p.analog_ready};
         4'h9: return {p.cmd_timeout, p.monitor_fail, p.monitor_pass, p.timeout_active, p.chip_timeout,
            p.single_chip_error, p.code_error, p.chip_check_valid, p.baud_error, p.baud_valid,
            p.rssi_outside, p.rssi_settled, p.amp_too_high, p.amp_too_high_valid, p.amp_too_low,
            p.amp_too_low_valid};
         default: return 16'h0000;
      endcase
   endfunction : expect_word

   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : summarize

   initial begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      summarize();
   end

   initial begin
      logic [3:0] sels [11];
      logic [31:0] modes [3];
      int n, n0;
      sels = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hF};
      modes = '{32'h10, 32'h20, 32'h00};
      reset = 1'b1;
      {wb_cyc, wb_stb, wb_we, cap_en} = 4'h0;
      wb_adr = 8'h00;
      wb_sel = 4'h0;
      wb_dat_w = 32'h0;
      probe = '0;
      normal_pins = '0;
      fail_count = 0;
      num_checks = 0;
      rnd[31:0] = $urandom(2120);
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      #1;
      chk("idle pins", 32'(pins), 32'(normal_pins));
      wb(1'b0, 8'h0C, 4'hF, 32'h0);
      chk("unmapped read", rd, 32'h0);
      wb(1'b1, CTRL_OFS, 4'hE, 32'h3);
      wb(1'b0, CTRL_OFS, 4'hF, 32'h0);
      chk("ctrl lane off", rd, 32'h0);
      for (int k = 0; k < 11; k++) begin
         rnd = {$urandom, $urandom, $urandom, $urandom, $urandom};
         probe <= rnd[$bits(rx_probe_t)-1:0];
         normal_pins <= rnd[159:154];
         wb(1'b1, CTRL_OFS, 4'h1, 32'(sels[k]));
         wb(1'b0, STATUS_OFS, 4'hF, 32'h0);
         chk("active", 32'(rd[ST_ACTIVE_BIT]), 32'h1);
         chk("oe_n", 32'({pins.data_oe_n, pins.sync_oe_n, pins.clk_oe_n}), 32'h0);
         cap_en <= 1'b1;
         n0 = word_count;
         n = 0;
         while (word_count < n0 + 3 && n < 4000) begin
            @(posedge mclk);
            n++;
         end
         chk("words seen", 32'(word_count >= n0 + 3), 32'h1);
         chk("word", 32'(last_word), 32'(expect_word(sels[k], probe)));
         chk("framing", 32'(frame_errors), 32'h0);
         if (k == 0) begin
            // Captures outrun the link, so the buffer must fill and overflow
            repeat (400) @(posedge mclk);
            // Read well clear of a word pop, once the next capture has refilled the slot
            @(negedge pins.sync_out);
            repeat (40) @(posedge mclk);
            wb(1'b0, STATUS_OFS, 4'hF, 32'h0);
            chk("fifo level", 32'(rd[8:4]), 32'd16);
            chk("words sent", 32'(rd[31:16] != 16'h0), 32'h1);
            wb(1'b0, DROP_OFS, 4'hF, 32'h0);
            chk("drops", 32'(rd[15:0] != 16'h0), 32'h1);
         end
         cap_en <= 1'b0;
         for (int m = 0; m < 3; m++) begin
            wb(1'b1, CTRL_OFS, 4'h1, (m < 2) ? (modes[m] | 32'(sels[k])) : 32'h0);
            @(posedge mclk);
            #1;
            chk("normal pins", 32'(pins), 32'(normal_pins));
         end
      end
      wb(1'b0, STATUS_OFS, 4'hF, 32'h0);
      chk("flushed", 32'({rd[8:4], rd[ST_ACTIVE_BIT]}), 32'h0);
      summarize();
   end

endmodule : tb_top

`default_nettype wire
